// ---- spi_port_consts.svh ----
// Register offsets, field positions and codes of the serial port
`ifndef SPI_PORT_CONSTS_SVH
`define SPI_PORT_CONSTS_SVH
`define SPI_OFF_STAT 4'h0
`define SPI_OFF_CFG 4'h4
`define SPI_OFF_BUF 4'h8
`define SPI_OFF_IRQ 4'hc
`define SPI_STAT_EN 15
`define SPI_STAT_SIDL 13
`define SPI_STAT_ROV 6
`define SPI_STAT_TBF 1
`define SPI_STAT_RBF 0
`define SPI_CFG_DISSCK 12
`define SPI_CFG_DISSDO 11
`define SPI_CFG_WIDE 10
`define SPI_CFG_SMP 9
`define SPI_CFG_CKE 8
`define SPI_CFG_SLAVE_SELECT_ENABLE 7
`define SPI_CFG_CKP 6
`define SPI_CFG_MST 5
`define SPI_CFG_SEC_HI 4
`define SPI_CFG_SEC_LO 2
`define SPI_CFG_PRI_HI 1
`define SPI_CFG_PRI_LO 0
`define SPI_CFG_W 13
`define SPI_IRQ_DONE 0
`define SPI_IRQ_ERR 1
`define SPI_IRQ_DONE_EN 8
`define SPI_IRQ_ERR_EN 9
`define SPI_IRQ_DMA_SEL 10
`define SPI_BITS_WORD 5'h10
`define SPI_BITS_BYTE 5'h08
`define SPI_PRI_1 2'h3
`define SPI_PRI_4 2'h2
`define SPI_PRI_16 2'h1
`define SPI_RATIO_1 7'h01
`define SPI_RATIO_4 7'h04
`define SPI_RATIO_16 7'h10
`define SPI_RATIO_64 7'h40
`define SPI_SEC_2 3'h6
`define SPI_SEC_BASE 4'h8
`endif

// ---- spi_port_pkg.sv ----
// Types shared by the serial port files
package spi_port_pkg;
	typedef enum logic [2:0] {
		st_idle = 3'b001,
		st_master = 3'b010,
		st_slave = 3'b100
	} xfer_state_t;
endpackage

// ---- pin_sync.sv ----
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ns
module pin_sync #(
	parameter int WIDTH = 3
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [WIDTH-1:0] d_i,
	output logic [WIDTH-1:0] q_o
);
	logic [WIDTH-1:0] meta;

	if (WIDTH < 1) begin : g_bad
		$error("pin_sync needs WIDTH of at least one");
	end

	for (genvar i = 0; i < WIDTH; i++) begin : g_bit
		always_ff @(posedge clk_i) begin
			if (rst_i) begin
				meta[i] <= 1'b0;
				q_o[i] <= 1'b0;
			end else begin
				meta[i] <= d_i[i];
				q_o[i] <= meta[i];
			end
		end
	end
endmodule

// ---- spi_master_slave_port.sv ----
// Serial port, master or slave, with Wishbone register access
//
// Behaviour
// - One 16-bit shift register moves data out and in during a transfer.
// - Link uses data in, data out, shift clock and active-low slave select.
// - Master drives the shift clock; slave takes it from the outside master.
// - Each transfer is 8 or 16 clock pulses, one bit out and in each.
// - Completion sets the done flag; an enable bit masks its request.
// - A separate error request is raised for receive overflow only.
// - Finished word moves to the receive buffer and sets receive-full.
// - Reading the buffer returns received data and clears receive-full.
// - Word completing while receive buffer is full sets overflow and is lost.
// - While overflow is set shift-clock edges are ignored.
// - On completion waiting transmit data moves into the shift register.
// - Writing the buffer loads transmit data and sets transmit-full.
// - In master mode a buffer write alone starts the transfer.
// - Enable bit takes over the pins; clearing it disables the port.
// - Idle-stop bit halts the port while the processor is idle.
// - Master clock is system clock over primary times secondary ratio.
// - Completion pulses a DMA request when this port is the chosen source.
// - Width bit picks 16-bit transfers when set, 8-bit when clear.
// - Polarity bit sets idle clock level; edge bit picks the data edge.
// - Master samples input at end of bit time when set, middle when clear.
// - Primary ratios 1, 4, 16, 64; secondary ratio is eight minus code.
//
// The Wishbone register port and the register addresses are this design's own decisions.
`timescale 1ns/1ns
`include "spi_port_consts.svh"
module spi_master_slave_port #(
	parameter int DIV_BITS = 10
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic cpu_idle_i,
	input wire logic serial_in_pin_i,
	output logic serial_out_pin_o,
	output logic serial_out_pin_oe_o,
	input wire logic shift_clock_pin_i,
	output logic shift_clock_pin_o,
	output logic shift_clock_pin_oe_o,
	input wire logic slave_select_n_i,
	output logic done_irq_o,
	output logic error_irq_o,
	output logic dma_req_o
);
	if (DIV_BITS < 10) begin : g_bad
		$error("DIV_BITS must hold the largest divide ratio of 512");
	end

	function automatic logic pick_msb(input logic [15:0] w, input logic wide);
		return wide ? w[15] : w[7];
	endfunction

	function automatic logic [4:0] word_bits(input logic wide);
		return wide ? `SPI_BITS_WORD : `SPI_BITS_BYTE;
	endfunction

	function automatic logic hit(input logic [3:0] a, input logic [3:0] off);
		return a == off;
	endfunction

	spi_port_pkg::xfer_state_t state;
	logic port_enable;
	logic idle_stop_select;
	logic receive_overflow_flag;
	logic transmit_full_flag;
	logic receive_full_flag;
	logic [`SPI_CFG_W-1:0] port_config_one;
	logic [15:0] transmit_holding_buffer;
	logic [15:0] receive_holding_buffer;
	logic [15:0] serial_shift_reg;
	logic transfer_done_irq_flag;
	logic transfer_done_irq_enable;
	logic error_irq_flag;
	logic error_irq_enable;
	logic dma_source_select;
	logic [4:0] bit_cnt;
	logic [5:0] edge_cnt;
	logic [DIV_BITS-1:0] div_cnt;
	logic rx_bit;
	logic sck_s;
	logic sdi_s;
	logic ss_n_s;
	logic sck_q;

	logic req;
	logic bus_wr;
	logic bus_rd;
	logic buf_wr;
	logic buf_rd;
	logic wide;
	logic cke;
	logic clock_polarity_select;
	logic master_select;
	logic active;
	logic selected;
	logic [4:0] nbits;
	logic [6:0] pri_ratio;
	logic [3:0] sec_ratio;
	logic [DIV_BITS-1:0] prod;
	logic [DIV_BITS-1:0] half;
	logic div_ok;
	logic half_tick;
	logic m_lead;
	logic m_edge;
	logic m_mid;
	logic m_shift;
	logic s_chg;
	logic s_mid;
	logic s_launch;
	logic slave_live;
	logic in_bit;
	logic [15:0] shift_in;
	logic [15:0] rx_word;
	logic shift_evt;
	logic done_evt;
	logic ovf_evt;
	logic start_ok;
	logic tx_take;

	// Pins come from the far side and must settle before any logic looks at them
	pin_sync #(.WIDTH(3)) u_sync (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.d_i({shift_clock_pin_i, serial_in_pin_i, slave_select_n_i}),
		.q_o({sck_s, sdi_s, ss_n_s})
	);

	assign req = wb_cyc_i & wb_stb_i;
	// Side effects happen once, on the edge where the master sees ack
	assign bus_wr = req & wb_ack_o & wb_we_i;
	assign bus_rd = req & wb_ack_o & ~wb_we_i;
	assign buf_wr = bus_wr & hit(wb_adr_i, `SPI_OFF_BUF) & (wb_sel_i[0] | wb_sel_i[1]);
	assign buf_rd = bus_rd & hit(wb_adr_i, `SPI_OFF_BUF);

	assign wide = port_config_one[`SPI_CFG_WIDE];
	assign cke = port_config_one[`SPI_CFG_CKE];
	assign clock_polarity_select = port_config_one[`SPI_CFG_CKP];
	assign master_select = port_config_one[`SPI_CFG_MST];
	assign nbits = word_bits(wide);
	assign active = port_enable & ~(idle_stop_select & cpu_idle_i);
	assign selected = ~port_config_one[`SPI_CFG_SLAVE_SELECT_ENABLE] | ~ss_n_s;

	// Divide ratio
	always_comb begin
		case (port_config_one[`SPI_CFG_PRI_HI:`SPI_CFG_PRI_LO])
			`SPI_PRI_1: pri_ratio = `SPI_RATIO_1;
			`SPI_PRI_4: pri_ratio = `SPI_RATIO_4;
			`SPI_PRI_16: pri_ratio = `SPI_RATIO_16;
			default: pri_ratio = `SPI_RATIO_64;
		endcase
	end
	assign sec_ratio = `SPI_SEC_BASE - {1'b0, port_config_one[`SPI_CFG_SEC_HI:`SPI_CFG_SEC_LO]};
	assign prod = DIV_BITS'(pri_ratio) * DIV_BITS'(sec_ratio);
	assign half = prod >> 1;
	// The two fastest settings cannot be served and never start a transfer
	assign div_ok = ~(port_config_one[`SPI_CFG_PRI_HI:`SPI_CFG_PRI_LO] == `SPI_PRI_1
		&& port_config_one[`SPI_CFG_SEC_HI:`SPI_CFG_SEC_LO] >= `SPI_SEC_2);
	// Odd ratios give an idle-level phase one cycle shorter than the active phase
	assign half_tick = (state == spi_port_pkg::st_master)
		& (div_cnt == half - 1'b1 || div_cnt == prod - 1'b1);

	// Master edge plan: data launched on one edge kind, sampled on the other
	assign m_lead = ~edge_cnt[0];
	assign m_edge = edge_cnt < {nbits, 1'b0};
	assign m_mid = half_tick & m_edge & (cke ? m_lead : ~m_lead);
	assign m_shift = half_tick & (cke ? (~m_lead & m_edge) : (m_lead & edge_cnt != 6'h00));

	// Slave edges come from the synchronised pin
	assign s_chg = sck_s != sck_q;
	assign s_mid = s_chg & (cke ? (sck_s != clock_polarity_select) : (sck_s == clock_polarity_select));
	assign s_launch = s_chg & (cke ? (sck_s == clock_polarity_select) : (sck_s != clock_polarity_select));
	assign slave_live = active & (state == spi_port_pkg::st_slave) & selected
		& ~receive_overflow_flag;

	assign in_bit = (master_select & port_config_one[`SPI_CFG_SMP]) ? sdi_s : (master_select ? rx_bit : sdi_s);
	assign shift_in = {serial_shift_reg[14:0], in_bit};
	assign rx_word = wide ? shift_in : {8'h00, shift_in[7:0]};
	assign shift_evt = (active & (state == spi_port_pkg::st_master) & m_shift) | (slave_live & s_mid);
	assign done_evt = shift_evt & (bit_cnt == nbits - 1'b1);
	assign ovf_evt = done_evt & receive_full_flag;
	assign start_ok = active & (state == spi_port_pkg::st_idle) & ~receive_overflow_flag
		& (master_select ? (transmit_full_flag & div_ok) : selected);
	assign tx_take = transmit_full_flag & (start_ok | ((state == spi_port_pkg::st_slave) & done_evt));

	// Transfer engine
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state <= spi_port_pkg::st_idle;
			serial_shift_reg <= 16'h0000;
			bit_cnt <= 5'h00;
			edge_cnt <= 6'h00;
			div_cnt <= '0;
			rx_bit <= 1'b0;
			shift_clock_pin_o <= 1'b0;
			serial_out_pin_o <= 1'b0;
		end else if (!port_enable) begin
			state <= spi_port_pkg::st_idle;
			bit_cnt <= 5'h00;
			edge_cnt <= 6'h00;
			div_cnt <= '0;
			shift_clock_pin_o <= clock_polarity_select;
		end else if (active) begin
			case (state)
				spi_port_pkg::st_idle: begin
					shift_clock_pin_o <= clock_polarity_select;
					if (start_ok) begin
						if (transmit_full_flag) begin
							serial_shift_reg <= transmit_holding_buffer;
							serial_out_pin_o <= pick_msb(transmit_holding_buffer, wide);
						end else begin
							serial_out_pin_o <= pick_msb(serial_shift_reg, wide);
						end
						bit_cnt <= 5'h00;
						edge_cnt <= 6'h00;
						div_cnt <= '0;
						state <= master_select ? spi_port_pkg::st_master : spi_port_pkg::st_slave;
					end
				end
				spi_port_pkg::st_master: begin
					div_cnt <= (div_cnt == prod - 1'b1) ? '0 : div_cnt + 1'b1;
					if (half_tick) begin
						edge_cnt <= edge_cnt + 6'h01;
					end
					if (half_tick & m_edge) begin
						shift_clock_pin_o <= ~shift_clock_pin_o;
					end
					if (m_mid) begin
						rx_bit <= sdi_s;
					end
					if (m_shift) begin
						serial_shift_reg <= shift_in;
						serial_out_pin_o <= pick_msb(shift_in, wide);
						bit_cnt <= bit_cnt + 5'h01;
						if (done_evt) begin
							bit_cnt <= 5'h00;
							state <= spi_port_pkg::st_idle;
						end
					end
				end
				spi_port_pkg::st_slave: begin
					if (!selected) begin
						bit_cnt <= 5'h00;
						state <= spi_port_pkg::st_idle;
					end else if (!receive_overflow_flag) begin
						if (s_mid) begin
							serial_shift_reg <= shift_in;
							bit_cnt <= bit_cnt + 5'h01;
							if (done_evt) begin
								bit_cnt <= 5'h00;
								if (transmit_full_flag) begin
									serial_shift_reg <= transmit_holding_buffer;
								end
							end
						end
						if (s_launch) begin
							serial_out_pin_o <= pick_msb(serial_shift_reg, wide);
						end
					end
				end
				default: state <= spi_port_pkg::st_idle;
			endcase
		end
	end

	// Edge history for the slave clock
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sck_q <= 1'b0;
		end else begin
			sck_q <= sck_s;
		end
	end

	// Pin drivers; a disabled port leaves every pin to the outside
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			shift_clock_pin_oe_o <= 1'b0;
			serial_out_pin_oe_o <= 1'b0;
		end else begin
			shift_clock_pin_oe_o <= port_enable & master_select & ~port_config_one[`SPI_CFG_DISSCK];
			serial_out_pin_oe_o <= port_enable & ~port_config_one[`SPI_CFG_DISSDO]
				& (master_select | (state == spi_port_pkg::st_slave && selected));
		end
	end

	// Status and control
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			port_enable <= 1'b0;
			idle_stop_select <= 1'b0;
			port_config_one <= '0;
		end else if (bus_wr) begin
			if (hit(wb_adr_i, `SPI_OFF_STAT) && wb_sel_i[1]) begin
				port_enable <= wb_dat_i[`SPI_STAT_EN];
				idle_stop_select <= wb_dat_i[`SPI_STAT_SIDL];
			end
			if (hit(wb_adr_i, `SPI_OFF_CFG)) begin
				if (wb_sel_i[0]) begin
					port_config_one[7:0] <= wb_dat_i[7:0];
				end
				if (wb_sel_i[1]) begin
					port_config_one[`SPI_CFG_W-1:8] <= wb_dat_i[`SPI_CFG_W-1:8];
				end
			end
		end
	end

	// Receive side; a read of a full buffer beats a simultaneous new word, which is lost
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			receive_full_flag <= 1'b0;
			receive_holding_buffer <= 16'h0000;
		end else if (done_evt & ~receive_full_flag) begin
			receive_holding_buffer <= rx_word;
			receive_full_flag <= 1'b1;
		end else if (buf_rd) begin
			receive_full_flag <= 1'b0;
		end
	end

	// Overflow is cleared only by writing zero to its bit
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			receive_overflow_flag <= 1'b0;
		end else if (ovf_evt) begin
			receive_overflow_flag <= 1'b1;
		end else if (bus_wr && hit(wb_adr_i, `SPI_OFF_STAT) && wb_sel_i[0]
			&& !wb_dat_i[`SPI_STAT_ROV]) begin
			receive_overflow_flag <= 1'b0;
		end
	end

	// Transmit side; a write in the same cycle as a hand-off keeps the new word pending
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			transmit_full_flag <= 1'b0;
			transmit_holding_buffer <= 16'h0000;
		end else if (buf_wr) begin
			transmit_holding_buffer <= wb_dat_i[15:0];
			transmit_full_flag <= 1'b1;
		end else if (tx_take) begin
			transmit_full_flag <= 1'b0;
		end
	end

	// Completion and error requests, write one to clear, set wins
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			transfer_done_irq_flag <= 1'b0;
			error_irq_flag <= 1'b0;
			transfer_done_irq_enable <= 1'b0;
			error_irq_enable <= 1'b0;
			dma_source_select <= 1'b0;
		end else begin
			if (done_evt) begin
				transfer_done_irq_flag <= 1'b1;
			end else if (bus_wr && hit(wb_adr_i, `SPI_OFF_IRQ) && wb_sel_i[0]
				&& wb_dat_i[`SPI_IRQ_DONE]) begin
				transfer_done_irq_flag <= 1'b0;
			end
			if (ovf_evt) begin
				error_irq_flag <= 1'b1;
			end else if (bus_wr && hit(wb_adr_i, `SPI_OFF_IRQ) && wb_sel_i[0]
				&& wb_dat_i[`SPI_IRQ_ERR]) begin
				error_irq_flag <= 1'b0;
			end
			if (bus_wr && hit(wb_adr_i, `SPI_OFF_IRQ) && wb_sel_i[1]) begin
				transfer_done_irq_enable <= wb_dat_i[`SPI_IRQ_DONE_EN];
				error_irq_enable <= wb_dat_i[`SPI_IRQ_ERR_EN];
				dma_source_select <= wb_dat_i[`SPI_IRQ_DMA_SEL];
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			done_irq_o <= 1'b0;
			error_irq_o <= 1'b0;
			dma_req_o <= 1'b0;
		end else begin
			done_irq_o <= transfer_done_irq_flag & transfer_done_irq_enable;
			error_irq_o <= error_irq_flag & error_irq_enable;
			dma_req_o <= done_evt & dma_source_select;
		end
	end

	// Wishbone slave: one wait cycle, unmapped reads give zero
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= req & ~wb_ack_o;
			wb_dat_o <= 32'h0000_0000;
			if (req & ~wb_ack_o & ~wb_we_i) begin
				case (wb_adr_i)
					`SPI_OFF_STAT: begin
						wb_dat_o[`SPI_STAT_EN] <= port_enable;
						wb_dat_o[`SPI_STAT_SIDL] <= idle_stop_select;
						wb_dat_o[`SPI_STAT_ROV] <= receive_overflow_flag;
						wb_dat_o[`SPI_STAT_TBF] <= transmit_full_flag;
						wb_dat_o[`SPI_STAT_RBF] <= receive_full_flag;
					end
					`SPI_OFF_CFG: wb_dat_o[`SPI_CFG_W-1:0] <= port_config_one;
					`SPI_OFF_BUF: wb_dat_o[15:0] <= receive_holding_buffer;
					`SPI_OFF_IRQ: begin
						wb_dat_o[`SPI_IRQ_DONE] <= transfer_done_irq_flag;
						wb_dat_o[`SPI_IRQ_ERR] <= error_irq_flag;
						wb_dat_o[`SPI_IRQ_DONE_EN] <= transfer_done_irq_enable;
						wb_dat_o[`SPI_IRQ_ERR_EN] <= error_irq_enable;
						wb_dat_o[`SPI_IRQ_DMA_SEL] <= dma_source_select;
					end
					default: wb_dat_o <= 32'h0000_0000;
				endcase
			end
		end
	end
endmodule

// ---- spi_port_asserts.sv ----
// Concurrent checks on the serial port bus, request and shift-clock pin-enable outputs
`timescale 1ns/1ns
module spi_port_asserts (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic shift_clock_pin_oe_o,
	input wire logic done_irq_o,
	input wire logic error_irq_o,
	input wire logic dma_req_o
);
	logic wr_done;
	assign wr_done = wb_ack_o & wb_we_i;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held too long");
	ack_latency_a: assert property ((wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
		else $error("ack late");
	ack_cause_a: assert property ($rose(wb_ack_o) |-> $past(wb_stb_i) && $past(wb_cyc_i))
		else $error("ack without request");
	rdata_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
		else $error("read data outside ack");
	rdata_upper_a: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0)
		else $error("upper read data set");
	done_hold_a: assert property (done_irq_o && !wb_ack_o && !$past(wb_ack_o) |=> done_irq_o)
		else $error("done request dropped alone");
	err_hold_a: assert property (error_irq_o && !wb_ack_o && !$past(wb_ack_o) |=> error_irq_o)
		else $error("error request dropped alone");
	dma_pulse_a: assert property (dma_req_o |=> !dma_req_o)
		else $error("dma request longer than a pulse");
	oe_cause_a: assert property ($changed(shift_clock_pin_oe_o) |-> $past(wr_done) || $past(wr_done, 2))
		else $error("clock enable changed without write");
endmodule
bind spi_master_slave_port spi_port_asserts u_chk (.clk_i(clk_i), .rst_i(rst_i),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_dat_o(wb_dat_o),
	.wb_ack_o(wb_ack_o), .shift_clock_pin_oe_o(shift_clock_pin_oe_o),
	.done_irq_o(done_irq_o), .error_irq_o(error_irq_o), .dma_req_o(dma_req_o));

// ---- spi_peer_model.sv ----
// Serial peripheral on the far side: samples on leading edge, shifts on trailing edge
`timescale 1ns/1ns
module spi_peer_model (
	input wire logic clk_i,
	input wire logic sck_i,
	input wire logic mosi_i,
	input wire logic [15:0] load_i,
	input wire logic load_en_i,
	output logic miso_o,
	output logic [15:0] got_o,
	output int half_o
);
	logic sck_q;
	logic [15:0] tx;
	int cnt;
	// Clock taken as input from the master, edges seen on the system clock
	always_ff @(posedge clk_i) begin
		sck_q <= sck_i;
		cnt <= cnt + 1;
		if (load_en_i) begin
			tx <= load_i;
		end else if (sck_i && !sck_q) begin
			got_o <= {got_o[14:0], mosi_i};
			half_o <= cnt + 1;
			cnt <= 0;
		end else if (!sck_i && sck_q) begin
			// Inverted fill so stale bits never look like the last value
			tx <= {tx[14:0], ~tx[0]};
			cnt <= 0;
		end
	end
	assign miso_o = tx[15];
endmodule

// ---- tb_spi_master_slave_port.sv ----
// Self-checking bench for the serial port as master against a peer model, and as slave
`timescale 1ns/1ns
`include "spi_port_consts.svh"
module tb_spi_master_slave_port;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [3:0] adr = 4'h0;
	logic [31:0] wdat = 32'h0;
	logic [31:0] rdat;
	logic [31:0] wb_dat_o;
	logic wb_ack_o;
	logic cpu_idle = 1'b0;
	logic miso, mosi, mosi_oe, sck, sck_oe, done_irq, err_irq, dma_req;
	logic [15:0] peer_word = 16'h0;
	logic peer_load = 1'b0;
	logic s_sdi = 1'b0;
	logic m_sck = 1'b0;
	logic ss_n = 1'b1;
	logic [15:0] peer_got;
	int peer_half;
	int fail_count = 0;
	int total_checks = 0;
	int dma_seen = 0;
	initial forever #20 clk_i = ~clk_i;
	spi_master_slave_port u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h3), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .cpu_idle_i(cpu_idle), .serial_in_pin_i(sck_oe ? miso : s_sdi),
		.serial_out_pin_o(mosi), .serial_out_pin_oe_o(mosi_oe), .shift_clock_pin_i(m_sck),
		.shift_clock_pin_o(sck), .shift_clock_pin_oe_o(sck_oe), .slave_select_n_i(ss_n),
		.done_irq_o(done_irq), .error_irq_o(err_irq), .dma_req_o(dma_req));
	spi_peer_model u_peer (.clk_i(clk_i), .sck_i(sck), .mosi_i(mosi), .load_i(peer_word),
		.load_en_i(peer_load), .miso_o(miso), .got_o(peer_got), .half_o(peer_half));
	always @(posedge clk_i) if (dma_req === 1'b1) dma_seen <= dma_seen + 1;
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("mismatch at %0t: got %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic give_verdict();
		if (fail_count == 0 && total_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	// Holds the request until ack is sampled; a hung slave counts as a mismatch
	task automatic wb_xfer(input logic wr, input logic [3:0] a, input logic [15:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= wr;
		adr <= a;
		wdat <= {16'h0, d};
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 50);
		rdat = wb_dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		if (wb_ack_o !== 1'b1) check(32'h0, 32'h1);
	endtask
	task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
		wb_xfer(1'b0, a, 16'h0);
		check(rdat, exp);
	endtask
	task automatic wait_done(input int target);
		int n;
		n = 0;
		while (dma_seen < target && n < 4000) begin
			@(posedge clk_i);
			n++;
		end
		check(32'(dma_seen >= target), 32'h1);
	endtask
	task automatic load_peer(input logic [15:0] w);
		@(posedge clk_i);
		peer_word <= w;
		peer_load <= 1'b1;
		@(posedge clk_i);
		peer_load <= 1'b0;
	endtask
	// Configure while disabled, then enable
	task automatic setup(input logic [15:0] cfg);
		wb_xfer(1'b1, `SPI_OFF_STAT, 16'h0000);
		wb_xfer(1'b1, `SPI_OFF_CFG, cfg);
		wb_xfer(1'b1, `SPI_OFF_STAT, 16'h8000);
		repeat (2) @(posedge clk_i);
		check({31'h0, sck_oe}, 32'h1);
	endtask
	task automatic t_reset();
		check({31'h0, sck_oe}, 32'h0);
		rd_chk(`SPI_OFF_STAT, 32'h0);
		rd_chk(`SPI_OFF_CFG, 32'h0);
		rd_chk(`SPI_OFF_IRQ, 32'h0);
		wb_xfer(1'b1, 4'h2, 16'hffff);
		rd_chk(4'h2, 32'h0);
	endtask
	task automatic t_word();
		int base;
		base = dma_seen;
		load_peer(16'ha5c3);
		wb_xfer(1'b1, `SPI_OFF_BUF, 16'h3c5a);
		wait_done(base + 1);
		check({16'h0, peer_got}, 32'h3c5a);
		check(peer_half, 32'd16);
		rd_chk(`SPI_OFF_STAT, 32'h8001);
		check({31'h0, done_irq}, 32'h1);
		rd_chk(`SPI_OFF_BUF, 32'ha5c3);
		rd_chk(`SPI_OFF_STAT, 32'h8000);
		wb_xfer(1'b1, `SPI_OFF_IRQ, 16'h0701);
		repeat (3) @(posedge clk_i);
		check({31'h0, done_irq}, 32'h0);
	endtask
	task automatic t_overflow();
		int base;
		setup(16'h0122);
		base = dma_seen;
		load_peer(16'h9600);
		wb_xfer(1'b1, `SPI_OFF_BUF, 16'h0041);
		wb_xfer(1'b1, `SPI_OFF_BUF, 16'h0082);
		rd_chk(`SPI_OFF_STAT, 32'h8002);
		wait_done(base + 2);
		check({24'h0, peer_got[7:0]}, 32'h82);
		rd_chk(`SPI_OFF_STAT, 32'h8041);
		check({31'h0, err_irq}, 32'h1);
		rd_chk(`SPI_OFF_BUF, 32'h0096);
		wb_xfer(1'b1, `SPI_OFF_BUF, 16'h005a);
		repeat (100) @(posedge clk_i);
		check(dma_seen, base + 2);
		rd_chk(`SPI_OFF_STAT, 32'h8042);
		load_peer(16'hc300);
		wb_xfer(1'b1, `SPI_OFF_STAT, 16'h8000);
		wait_done(base + 3);
		check({24'h0, peer_got[7:0]}, 32'h5a);
		rd_chk(`SPI_OFF_BUF, 32'h00c3);
		wb_xfer(1'b1, `SPI_OFF_IRQ, 16'h0703);
		repeat (3) @(posedge clk_i);
		check({30'h0, err_irq, done_irq}, 32'h0);
	endtask
	// Idle asserted mid-byte: a running port would finish well inside the wait
	task automatic t_idle();
		int base;
		wb_xfer(1'b1, `SPI_OFF_CFG, 16'h0322);
		wb_xfer(1'b1, `SPI_OFF_STAT, 16'ha000);
		base = dma_seen;
		load_peer(16'h3c00);
		wb_xfer(1'b1, `SPI_OFF_BUF, 16'h00e7);
		repeat (40) @(posedge clk_i);
		cpu_idle <= 1'b1;
		repeat (400) @(posedge clk_i);
		check(dma_seen, base);
		cpu_idle <= 1'b0;
		wait_done(base + 1);
		check({24'h0, peer_got[7:0]}, 32'he7);
		rd_chk(`SPI_OFF_BUF, 32'h003c);
	endtask
	// Bench plays the outside master; edges four cycles apart cover the synchroniser delay
	task automatic t_slave();
		int base;
		logic [7:0] got;
		logic [7:0] pat;
		base = dma_seen;
		pat = 8'h3c;
		got = 8'h00;
		wb_xfer(1'b1, `SPI_OFF_STAT, 16'h0000);
		wb_xfer(1'b1, `SPI_OFF_BUF, 16'h00a5);
		wb_xfer(1'b1, `SPI_OFF_CFG, 16'h0180);
		wb_xfer(1'b1, `SPI_OFF_STAT, 16'h8000);
		@(posedge clk_i);
		ss_n <= 1'b0;
		for (int i = 7; i >= 0; i--) begin
			s_sdi <= pat[i];
			repeat (4) @(posedge clk_i);
			got[i] = mosi;
			m_sck <= 1'b1;
			repeat (4) @(posedge clk_i);
			m_sck <= 1'b0;
		end
		check({31'h0, mosi_oe}, 32'h1);
		check({31'h0, sck_oe}, 32'h0);
		check({24'h0, got}, 32'ha5);
		repeat (4) @(posedge clk_i);
		check(dma_seen, base + 1);
		rd_chk(`SPI_OFF_STAT, 32'h8001);
		rd_chk(`SPI_OFF_BUF, 32'h003c);
		ss_n <= 1'b1;
	endtask
	task automatic t_invalid();
		setup(16'h013f);
		wb_xfer(1'b1, `SPI_OFF_BUF, 16'h0011);
		repeat (100) @(posedge clk_i);
		rd_chk(`SPI_OFF_STAT, 32'h8002);
		wb_xfer(1'b1, `SPI_OFF_STAT, 16'h0000);
		repeat (3) @(posedge clk_i);
		check({31'h0, sck_oe}, 32'h0);
	endtask
	initial begin
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		t_reset();
		wb_xfer(1'b1, `SPI_OFF_IRQ, 16'h0700);
		setup(16'h0522);
		t_word();
		t_overflow();
		t_idle();
		t_invalid();
		t_slave();
		give_verdict();
	end
	initial begin
		repeat (20000) @(posedge clk_i);
		fail_count++;
		give_verdict();
	end
endmodule
